/* core/apc_power_reset.v */
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "apc_defs.vh"

module apc_power_reset #(
    parameter integer CLK_HZ     = `APC_CLK_HZ,
    parameter integer MS_CYCLES  = CLK_HZ / 1000,
    parameter integer ON_HOLD_MS = `APC_T_ON_HOLD_MS,
    parameter integer LONG_MS    = `APC_T_LONG_HOLD_MS,
    parameter integer EXTRA_MS   = `APC_T_EXTRA_MS,
    parameter integer RST_MS     = `APC_T_RST_MS
) (
    input  wire        CLK,
    input  wire        RST,
    input  wire [3:0]  ADDR,
    input  wire [15:0] WDATA,
    input  wire        WR,
    input  wire        RD,
    output reg  [15:0] RDATA,
    input  wire        SENSE_PIN_ONE,
    input  wire        KEY_CONFIRM,
    input  wire        KEY_CANCEL,
    input  wire        WDOG_RESET,
    output reg         PWR_SW_O,
    output reg         PWR_SW_OE,
    output reg         HOST_RST_O,
    output reg         HOST_RST_OE,
    output reg         DISPLAY_BLANK,
    output reg         SELF_REBOOT
);

    // =========================================================
    // States
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_PON   = 3'h1;
    localparam [2:0] ST_POFF  = 3'h2;
    localparam [2:0] ST_PEXT  = 3'h3;
    localparam [2:0] ST_HRST  = 3'h4;
    localparam [2:0] ST_BOOT  = 3'h5;
    localparam [2:0] ST_WAIT  = 3'h6;

    // =========================================================
    // Registers
    reg  [7:0]  ctrl_q;
    reg  [15:0] pulse_ms_q;
    wire        ms_tick_q;
    reg  [15:0] hold_ms_q;
    reg  [15:0] act_ms_q;
    reg  [2:0]  state_q;

    wire sense_on = SENSE_PIN_ONE; // Pad pull-down makes floating read as off
    wire en_on    = ctrl_q[`APC_CTRL_EN_ON];
    wire en_off   = ctrl_q[`APC_CTRL_EN_OFF];
    wire en_rst   = ctrl_q[`APC_CTRL_EN_RST];
    wire pwr_inv  = ctrl_q[`APC_CTRL_PWR_INV];
    wire rst_inv  = ctrl_q[`APC_CTRL_RST_INV];
    wire any_key  = KEY_CONFIRM | KEY_CANCEL;

    // Sequence that a held key qualifies, given current sense level
    wire want_on  = en_on  & ~sense_on & KEY_CONFIRM;
    wire want_off = en_off &  sense_on & KEY_CANCEL;
    wire want_rst = en_rst &  sense_on & KEY_CONFIRM;
    wire holding  = want_on | want_off | want_rst;

    // =========================================================
    // Register port; no fan state lives here, sense only appears in the status readback
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_q     <= `APC_CTRL_RESET_VAL;
            pulse_ms_q <= `APC_PULSE_RESET_VAL;
            RDATA      <= 16'h0000;
        end else begin
            if (WR && ADDR == `APC_ADDR_CTRL)
                ctrl_q <= WDATA[7:0];
            if (WR && ADDR == `APC_ADDR_PULSE)
                pulse_ms_q <= (WDATA == 16'h0000) ? 16'h0001 : WDATA;
            if (RD) begin
                case (ADDR)
                    `APC_ADDR_CTRL:   RDATA <= {8'h00, ctrl_q};
                    `APC_ADDR_PULSE:  RDATA <= pulse_ms_q;
                    `APC_ADDR_STATUS: RDATA <= {11'h000, state_q, KEY_CANCEL, sense_on};
                    default:          RDATA <= 16'h0000;
                endcase
            end else begin
                RDATA <= 16'h0000;
            end
        end
    end

    // =========================================================
    // Millisecond time base
    // Slow ticks keep every hold and pulse counter at 16 bits;
    // the price is a timing grain of one millisecond.
    apc_ms_base #(
        .DIV    (MS_CYCLES),
        .WIDTH  (32)
    ) apc_ms_base_inst (
        .CLK    (CLK),
        .RST    (RST),
        .TICK   (ms_tick_q)
    );

    // =========================================================
    // Key sequencer
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_q     <= ST_IDLE;
            hold_ms_q   <= 16'h0000;
            act_ms_q    <= 16'h0000;
            PWR_SW_O    <= 1'b0;
            PWR_SW_OE   <= 1'b0;
            HOST_RST_O  <= 1'b0;
            HOST_RST_OE <= 1'b0;
            SELF_REBOOT <= 1'b0;
        end else begin
            SELF_REBOOT <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    PWR_SW_OE   <= 1'b0;
                    PWR_SW_O    <= 1'b0;
                    // Watchdog shares the reset pin with key resets
                    HOST_RST_OE <= WDOG_RESET;
                    // Watchdog drives the same active level as a key reset
                    HOST_RST_O  <= WDOG_RESET ? rst_inv : 1'b0;
                    if (!holding)
                        hold_ms_q <= 16'h0000;
                    else if (ms_tick_q)
                        hold_ms_q <= hold_ms_q + 16'h0001;
                    if (want_on && hold_ms_q >= ON_HOLD_MS[15:0]) begin
                        state_q   <= ST_PON;
                        act_ms_q  <= 16'h0000;
                        PWR_SW_OE <= 1'b1;
                        PWR_SW_O  <= pwr_inv;
                    end else if (want_off && hold_ms_q >= LONG_MS[15:0]) begin
                        state_q   <= ST_POFF;
                        act_ms_q  <= 16'h0000;
                        PWR_SW_OE <= 1'b1;
                        PWR_SW_O  <= pwr_inv;
                    end else if (want_rst && hold_ms_q >= LONG_MS[15:0] && !WDOG_RESET) begin
                        state_q     <= ST_HRST;
                        act_ms_q    <= 16'h0000;
                        HOST_RST_OE <= 1'b1;
                        HOST_RST_O  <= rst_inv;
                    end
                end
                ST_PON, ST_POFF: begin
                    if (ms_tick_q)
                        act_ms_q <= act_ms_q + 16'h0001;
                    if (ms_tick_q && act_ms_q + 16'h0001 >= pulse_ms_q) begin
                        act_ms_q <= 16'h0000;
                        if (state_q == ST_POFF && KEY_CANCEL) begin
                            state_q <= ST_PEXT;
                        end else begin
                            state_q   <= ST_WAIT;
                            PWR_SW_OE <= 1'b0;
                            PWR_SW_O  <= 1'b0;
                        end
                    end
                end
                ST_PEXT: begin
                    if (ms_tick_q)
                        act_ms_q <= act_ms_q + 16'h0001;
                    if (!KEY_CANCEL || (ms_tick_q && act_ms_q + 16'h0001 >= EXTRA_MS[15:0])) begin
                        state_q   <= ST_WAIT;
                        PWR_SW_OE <= 1'b0;
                        PWR_SW_O  <= 1'b0;
                    end
                end
                ST_HRST: begin
                    if (ms_tick_q)
                        act_ms_q <= act_ms_q + 16'h0001;
                    if (ms_tick_q && act_ms_q + 16'h0001 >= RST_MS[15:0]) begin
                        state_q     <= ST_BOOT;
                        HOST_RST_OE <= 1'b0;
                        HOST_RST_O  <= 1'b0;
                    end
                end
                ST_BOOT: begin
                    SELF_REBOOT <= 1'b1;
                    state_q     <= ST_WAIT;
                end
                ST_WAIT: begin
                    // Key must be released first so one press gives one pulse
                    hold_ms_q <= 16'h0000;
                    if (!any_key)
                        state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // =========================================================
    // Display blanking follows sense while enabled
    always @(posedge CLK or posedge RST) begin
        if (RST)
            DISPLAY_BLANK <= 1'b0;
        else
            DISPLAY_BLANK <= ctrl_q[`APC_CTRL_BLANK] & ~sense_on;
    end

endmodule // apc_power_reset

// =============================================================
// Millisecond tick generator
// One-cycle strobe every DIV clocks. Kept as its own module so a
// different clock rate only changes the divide parameter.
// Limitation: DIV must be at least 1; a DIV of 1 gives a tick
// on every clock edge after reset.
module apc_ms_base #(
    parameter integer DIV   = `APC_CLK_HZ / 1000,
    parameter integer WIDTH = 32
) (
    input  wire CLK,
    input  wire RST,
    output reg  TICK
);

    // =========================================================
    // Terminal count, cut to the counter width on purpose
    localparam [WIDTH-1:0] LAST = DIV - 1;
    localparam [WIDTH-1:0] ONE  = 1;

    reg  [WIDTH-1:0] cnt_q;

    // =========================================================
    // Free-running divider; tick is registered so it never glitches
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            cnt_q <= {WIDTH{1'b0}};
            TICK  <= 1'b0;
        end else if (cnt_q == LAST) begin
            cnt_q <= {WIDTH{1'b0}};
            TICK  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + ONE;
            TICK  <= 1'b0;
        end
    end

endmodule // apc_ms_base

`default_nettype wire

/* shared/apc_defs.vh */
`ifndef APC_DEFS_VH
`define APC_DEFS_VH

// Register offsets on the plain register port
`define APC_ADDR_CTRL      4'h0
`define APC_ADDR_PULSE     4'h1
`define APC_ADDR_STATUS    4'h2

// Control register field positions
`define APC_CTRL_EN_ON     0
`define APC_CTRL_EN_OFF    1
`define APC_CTRL_EN_RST    2
`define APC_CTRL_PWR_INV   3
`define APC_CTRL_RST_INV   4
`define APC_CTRL_BLANK     5
`define APC_CTRL_RESET_VAL 8'h00

// Clock rate in hertz, times in milliseconds
`define APC_CLK_HZ         50000000
`define APC_T_ON_HOLD_MS   250
`define APC_T_LONG_HOLD_MS 4000
`define APC_T_PULSE_MS     1000
`define APC_T_EXTRA_MS     5000
`define APC_T_RST_MS       1000
// Pulse width register counts milliseconds
`define APC_PULSE_RESET_VAL 16'h03E8

`endif

/* verif/apc_power_reset_chk.sv */
`timescale 1ns/100ps
`default_nettype none
`include "apc_defs.vh"
// ========================================
// Port checker for the power/reset sequencer
module apc_power_reset_chk #(
    parameter integer MS_CYCLES = 50000,
    parameter integer RST_MS    = 1000
) (
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic [3:0]  ADDR,
    input wire logic [15:0] WDATA,
    input wire logic        WR,
    input wire logic        SENSE_PIN_ONE,
    input wire logic        KEY_CONFIRM,
    input wire logic        KEY_CANCEL,
    input wire logic        WDOG_RESET,
    input wire logic        PWR_SW_O,
    input wire logic        PWR_SW_OE,
    input wire logic        HOST_RST_O,
    input wire logic        HOST_RST_OE,
    input wire logic        DISPLAY_BLANK,
    input wire logic        SELF_REBOOT
);
    localparam integer RMIN = (RST_MS - 1) * MS_CYCLES - 1;
    localparam integer RMAX = (RST_MS + 1) * MS_CYCLES + 1;
    logic [7:0]  ctrl_q;
    logic [31:0] rcnt_q;
    wire         on_req = SENSE_PIN_ONE ? KEY_CANCEL & ctrl_q[1] : KEY_CONFIRM & ctrl_q[0];
    wire         rs_req = WDOG_RESET | (KEY_CONFIRM & SENSE_PIN_ONE & ctrl_q[2]);
    // Control shadow; reset length counter, since the width is only known at its end
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_q <= `APC_CTRL_RESET_VAL;
            rcnt_q <= 32'h0;
        end else begin
            if (WR && ADDR == `APC_ADDR_CTRL) ctrl_q <= WDATA[7:0];
            rcnt_q <= HOST_RST_OE ? rcnt_q + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    a_pwr_polarity: assert property (PWR_SW_OE |-> PWR_SW_O == ctrl_q[3])
        else $error("power drive level wrong");
    a_rst_polarity: assert property (HOST_RST_OE |-> HOST_RST_O == ctrl_q[4])
        else $error("reset drive level wrong");
    a_pwr_cause: assert property ($rose(PWR_SW_OE) |-> $past(on_req))
        else $error("power pulse without enabled key");
    a_rst_cause: assert property ($rose(HOST_RST_OE) |-> $past(rs_req))
        else $error("reset pulse without cause");
    a_rst_bounded: assert property (rcnt_q <= RMAX)
        else $error("reset pulse too long");
    a_reboot_after: assert property (SELF_REBOOT |-> $past(rcnt_q) >= RMIN)
        else $error("reboot not after full reset");
    a_reboot_single: assert property (SELF_REBOOT |=> !SELF_REBOOT)
        else $error("reboot pulse too long");
    a_blank_on: assert property ((ctrl_q[5] && !SENSE_PIN_ONE) [*2] |=> DISPLAY_BLANK)
        else $error("display not blanked");
    a_blank_off: assert property ((!ctrl_q[5] || SENSE_PIN_ONE) [*2] |=> !DISPLAY_BLANK)
        else $error("display blanked wrongly");
endmodule // apc_power_reset_chk
bind apc_power_reset apc_power_reset_chk #(.MS_CYCLES(MS_CYCLES), .RST_MS(RST_MS)) apc_power_reset_chk_inst (
    .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .SENSE_PIN_ONE(SENSE_PIN_ONE),
    .KEY_CONFIRM(KEY_CONFIRM), .KEY_CANCEL(KEY_CANCEL), .WDOG_RESET(WDOG_RESET), .PWR_SW_O(PWR_SW_O),
    .PWR_SW_OE(PWR_SW_OE), .HOST_RST_O(HOST_RST_O), .HOST_RST_OE(HOST_RST_OE),
    .DISPLAY_BLANK(DISPLAY_BLANK), .SELF_REBOOT(SELF_REBOOT));
`default_nettype wire

/* verif/apc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ========================================
// Host board: pulled-up switch inputs, supply flips per power press
module apc_host_model (
    input  wire logic CLK,
    input  wire logic RST,
    input  wire logic PWR_SW_O,
    input  wire logic PWR_SW_OE,
    input  wire logic HOST_RST_O,
    input  wire logic HOST_RST_OE,
    output var  logic SENSE,
    output wire logic PWR_LINE,
    output wire logic RST_LINE
);
    logic oe_q;
    // Plain switch inputs, nothing else on them; released lines float up
    assign PWR_LINE = PWR_SW_OE ? PWR_SW_O : 1'b1;
    assign RST_LINE = HOST_RST_OE ? HOST_RST_O : 1'b1;
    // Supply toggles when a press ends, whatever its polarity
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            oe_q  <= 1'b0;
            SENSE <= 1'b0;
        end else begin
            oe_q <= PWR_SW_OE;
            if (oe_q && !PWR_SW_OE) SENSE <= !SENSE;
        end
    end
endmodule // apc_host_model
`default_nettype wire

/* verif/tb_apc_power_reset.sv */
`timescale 1ns/100ps
`default_nettype none
`include "apc_defs.vh"
module tb_apc_power_reset;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        k_ok = 1'b0;
    logic        k_no = 1'b0;
    logic        wdog = 1'b0;
    logic        sel = 1'b0;
    wire  [15:0] rdata;
    wire         sense, pwr_o, pwr_oe, rst_o, rst_oe, blank, reboot, pwr_ln, rst_ln;
    wire         oe_s = sel ? rst_oe : pwr_oe;
    wire         ln_s = sel ? rst_ln : pwr_ln;
    integer      failures = 0;
    integer      checks_done = 0;
    // Short millisecond tick and times of 4 to 6 ms keep the counts cheap
    apc_power_reset #(.MS_CYCLES(2), .ON_HOLD_MS(6), .LONG_MS(6), .EXTRA_MS(4), .RST_MS(5)) apc_power_reset_inst (
        .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .SENSE_PIN_ONE(sense), .KEY_CONFIRM(k_ok), .KEY_CANCEL(k_no), .WDOG_RESET(wdog),
        .PWR_SW_O(pwr_o), .PWR_SW_OE(pwr_oe), .HOST_RST_O(rst_o), .HOST_RST_OE(rst_oe),
        .DISPLAY_BLANK(blank), .SELF_REBOOT(reboot));
    apc_host_model apc_host_model_inst (.CLK(clk), .RST(rst), .PWR_SW_O(pwr_o), .PWR_SW_OE(pwr_oe),
        .HOST_RST_O(rst_o), .HOST_RST_OE(rst_oe), .SENSE(sense), .PWR_LINE(pwr_ln), .RST_LINE(rst_ln));
    initial forever #10 clk = ~clk;
    // ========================================
    // Compare and bus tasks
    task chk(input [15:0] g, input [15:0] e);
        checks_done = checks_done + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task in_rng(input integer v, input integer lo, input integer hi);
        checks_done = checks_done + 1;
        if (v < lo || v > hi) begin
            failures = failures + 1;
            $display("[ERR] %0t count %0d out of range", $time, v);
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wreg(input [3:0] a, input [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rreg(input [3:0] a, input [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        cyc(1);
        rd <= 1'b0;
        chk(rdata, e);
    endtask
    // Time a drive pulse on the selected line: delay, width, driven level
    task pulse(input s, input integer llo, input integer lhi, input integer whi, input lv);
        integer n;
        integer w;
        sel = s;
        n = 0;
        w = 0;
        while (oe_s !== 1'b1 && n < 300) begin
            cyc(1);
            n = n + 1;
        end
        in_rng(n, llo, lhi);
        chk({15'h0, ln_s}, {15'h0, lv});
        while (oe_s === 1'b1 && w < 300) begin
            cyc(1);
            w = w + 1;
        end
        in_rng(w, whi - 4, whi);
        chk({15'h0, ln_s}, 16'h0001);
    endtask
    // ========================================
    // Scenarios
    task t_regs;
        rreg(`APC_ADDR_CTRL, 16'h0000);
        rreg(`APC_ADDR_PULSE, `APC_PULSE_RESET_VAL);
        rreg(4'hF, 16'h0000);
        wreg(`APC_ADDR_PULSE, 16'h0000);
        rreg(`APC_ADDR_PULSE, 16'h0001);
    endtask
    task t_off_idle;
        integer hit;
        hit = 0;
        wreg(`APC_ADDR_CTRL, 16'h0020);
        k_ok <= 1'b1;
        repeat (30) begin
            cyc(1);
            hit = hit | pwr_oe;
        end
        k_ok <= 1'b0;
        chk(hit[15:0], 16'h0000);
        chk({15'h0, blank}, 16'h0001);
    endtask
    task t_power_on;
        wreg(`APC_ADDR_PULSE, 16'h0004);
        wreg(`APC_ADDR_CTRL, 16'h0021);
        k_ok <= 1'b1;
        cyc(8);
        k_ok <= 1'b0;
        cyc(2);
        k_ok <= 1'b1;
        pulse(0, 9, 16, 10, 0);
        k_ok <= 1'b0;
        cyc(4);
        chk({14'h0, sense, blank}, 16'h0002);
    endtask
    task t_reset;
        integer n;
        n = 0;
        wreg(`APC_ADDR_CTRL, 16'h0014);
        k_ok <= 1'b1;
        pulse(1, 9, 16, 12, 1);
        k_ok <= 1'b0;
        while (reboot !== 1'b1 && n < 20) begin
            cyc(1);
            n = n + 1;
        end
        in_rng(n, 0, 2);
    endtask
    task t_wdog;
        wreg(`APC_ADDR_CTRL, 16'h0002);
        wdog <= 1'b1;
        cyc(4);
        chk({14'h0, rst_oe, rst_ln}, 16'h0002);
        wdog <= 1'b0;
        cyc(4);
        chk({15'h0, rst_oe}, 16'h0000);
    endtask
    task t_force_off;
        wreg(`APC_ADDR_CTRL, 16'h000A);
        k_no <= 1'b1;
        pulse(0, 9, 16, 18, 1);
        k_no <= 1'b0;
        cyc(4);
        chk({15'h0, sense}, 16'h0000);
    endtask
    task report_and_stop;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        #200000;
        failures = failures + 1;
        report_and_stop;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        t_regs;
        t_off_idle;
        t_power_on;
        t_reset;
        t_wdog;
        t_force_off;
        report_and_stop;
    end
endmodule // tb_apc_power_reset
`default_nettype wire
